// *** core/asrt_pkg.sv ***
package asrt_pkg;

   // Register byte offsets on the bus
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_TX_DIV = 8'h04;
   localparam logic [7:0] OFS_RX_DIV = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_RXBUF = 8'h10;
   localparam logic [7:0] OFS_TXBUF = 8'h14;

   // Control register field positions
   localparam int CTRL_PAR_EN = 0;
   localparam int CTRL_PAR_ODD = 1;
   localparam int CTRL_STOP_LO = 2;
   localparam int CTRL_LEN_LO = 4;
   localparam int CTRL_W = 6;

   // Status register field positions
   localparam int STAT_DA = 0;
   localparam int STAT_PERR = 1;
   localparam int STAT_FERR = 2;
   localparam int STAT_OERR = 3;
   localparam int STAT_TX_RDY = 4;

   // Values after reset
   localparam logic [5:0] CTRL_RST = 6'h30;
   localparam logic [15:0] DIV_RST = 16'h028B;

   // Bit clock counts: 16 ticks per bit, receiver samples on the 8th
   localparam logic [3:0] TICK_LAST = 4'hF;
   localparam logic [3:0] TICK_MID = 4'h7;
   localparam logic [5:0] STOP1_LAST = 6'h0F;
   localparam logic [5:0] STOP15_LAST = 6'h17;
   localparam logic [5:0] STOP2_LAST = 6'h1F;

   // Stop length codes
   localparam logic [1:0] STOP_ONE = 2'h0;
   localparam logic [1:0] STOP_ONE_HALF = 2'h1;

   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRK} asrt_rx_type;
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} asrt_tx_type;

   typedef struct packed {
      logic [1:0] len;
      logic [1:0] stop_sel;
      logic par_odd;
      logic par_en;
   } asrt_cfg_type;

   typedef struct packed {
      // Serial input synchroniser and filtered level
      logic [2:0] rx_sync;
      logic rx_lvl;
      logic rx_prev;
      // Bit clock dividers
      logic [15:0] rx_div_cnt;
      logic [15:0] tx_div_cnt;
      // Receiver
      asrt_rx_type rx_st;
      logic [3:0] rx_tick;
      logic [2:0] rx_bit;
      logic [7:0] rx_sh;
      logic rx_par;
      logic [7:0] rx_hold;
      logic da;
      logic perr;
      logic ferr;
      logic oerr;
      // Transmitter
      asrt_tx_type tx_st;
      logic [5:0] tx_tick;
      logic [2:0] tx_bit;
      logic [7:0] tx_sh;
      logic tx_line;
      logic [7:0] tx_buf;
      logic tx_full;
      // Software registers
      asrt_cfg_type cfg;
      logic [15:0] tx_div;
      logic [15:0] rx_div;
      // Bus data phase
      logic dp_wr;
      logic [7:0] dp_addr;
      logic [31:0] rdata;
   } asrt_state_type;

endpackage

// *** core/asrt_core.sv ***
// The placing of the registers and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ns
// Operation
// - Character: start bit, five to eight data bits, optional parity, chosen stop length.
// - Stop bits and idle line are mark; start bit is space.
// - Transmit start bit aligned to bit clock, always sixteen ticks long.
// - Start shorter than half a bit is discarded; bits sampled mid-bit.
// - Idle receiver waits for mark-to-space, then mark sample aborts, space proceeds.
// - Parity enabled: parity of data plus parity bit checked against sense.
// - Parity disabled: no parity bit expected, parity error held low.
// - First stop bit sampled; space there raises framing error.
// - After stop sample, shift register copied to holding register, data-available set.
// - Data-available event updates parity, framing, overrun flags once per character.
// - Character completing while data-available still set raises overrun.
// - Host read of receive buffer clears data-available.
// - Stuck space: one all-space character, framing error, wait for mark.
// - Idle transmitter holds serial output at mark.
// - Buffer write starts start bit within one bit clock tick when idle.
// - End-of-character high between characters; no load into shift while low, except at the tick the last stop ends.
// - Buffer loaded during shifting: next start follows last stop directly.
// - Stop length of 1, 1.5 or 2 bits by counting bit clock ticks in the stop state.
// - Loading shift register from buffer sets transmit-ready flag.
// - End-of-character stays internal, not readable by software.
// - Data bits go least significant first, between start and parity.
module asrt_core #(
   parameter int DIV_W = 16
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Serial line
   input wire logic rx_serial,
   output logic tx_serial
);

   if (DIV_W < 2 || DIV_W > 16)
   begin : g_chk
      $error("DIV_W must be 2 to 16");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Right-align a character that was shifted in from the top
   function automatic logic [7:0] align(input logic [7:0] sh, input logic [1:0] len);
      logic [7:0] r;
      r = sh >> (3'd3 - {1'b0, len});
      return r;
   endfunction

   // Even parity over the active data bits
   function automatic logic par_of(input logic [7:0] d, input logic [1:0] len);
      logic [7:0] m;
      m = 8'hFF >> (3'd3 - {1'b0, len});
      return ^(d & m);
   endfunction

   // Divisor limited to the counter width that is built
   function automatic logic [15:0] div_lim(input logic [15:0] div);
      logic [15:0] r;
      r = div & 16'(~(17'h1_FFFF << DIV_W));
      return r;
   endfunction

   // A tick ends each divisor period; divisor 0 or 1 ticks every cycle
   function automatic logic tick_due(input logic [15:0] cnt, input logic [15:0] lim);
      logic t;
      t = cnt >= lim - 16'd1 || lim < 16'd2;
      return t;
   endfunction

   // Last tick of the stop state: 1, 1.5 or 2 bits
   function automatic logic [5:0] stop_end(input logic [1:0] sel);
      logic [5:0] r;
      unique case (sel)
         asrt_pkg::STOP_ONE: r = asrt_pkg::STOP1_LAST;
         asrt_pkg::STOP_ONE_HALF: r = asrt_pkg::STOP15_LAST;
         default: r = asrt_pkg::STOP2_LAST;
      endcase
      return r;
   endfunction

   function automatic logic [31:0] read_mux(input asrt_pkg::asrt_state_type s, input logic [7:0] a);
      logic [31:0] r;
      r = 32'h0000_0000;
      unique case (a)
         asrt_pkg::OFS_CTRL: r[asrt_pkg::CTRL_W-1:0] = s.cfg;
         asrt_pkg::OFS_TX_DIV: r[15:0] = s.tx_div;
         asrt_pkg::OFS_RX_DIV: r[15:0] = s.rx_div;
         asrt_pkg::OFS_STATUS:
         begin
            r[asrt_pkg::STAT_DA] = s.da;
            r[asrt_pkg::STAT_PERR] = s.perr;
            r[asrt_pkg::STAT_FERR] = s.ferr;
            r[asrt_pkg::STAT_OERR] = s.oerr;
            r[asrt_pkg::STAT_TX_RDY] = !s.tx_full;
         end
         asrt_pkg::OFS_RXBUF: r[7:0] = s.rx_hold;
         default: r = 32'h0000_0000;
      endcase
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // State

   asrt_pkg::asrt_state_type s_r;
   asrt_pkg::asrt_state_type s_nxt;

   logic addr_ph;
   logic rd_rxbuf;
   logic rx_tick;
   logic tx_tick;
   logic rx_smp;
   logic [15:0] rx_lim;
   logic [15:0] tx_lim;
   logic [5:0] stop_last;
   logic [2:0] last_bit;
   logic eoc;

   // Zero wait states: every transfer ends after one data phase
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_r.rdata;
   assign tx_serial = s_r.tx_line;

   always_comb
   begin
      s_nxt = s_r;
      addr_ph = hsel && htrans[1] && hready;
      rd_rxbuf = addr_ph && !hwrite && haddr == asrt_pkg::OFS_RXBUF;
      rx_lim = div_lim(s_r.rx_div);
      tx_lim = div_lim(s_r.tx_div);
      last_bit = 3'd4 + {1'b0, s_r.cfg.len};
      // End-of-character only gates the load; no status bit shows it
      eoc = s_r.tx_st == asrt_pkg::TX_IDLE;
      stop_last = stop_end(s_r.cfg.stop_sel);

      // Bit clocks at sixteen times baud
      rx_tick = tick_due(s_r.rx_div_cnt, rx_lim);
      tx_tick = tick_due(s_r.tx_div_cnt, tx_lim);
      s_nxt.rx_div_cnt = rx_tick ? 16'h0000 : s_r.rx_div_cnt + 16'd1;
      s_nxt.tx_div_cnt = tx_tick ? 16'h0000 : s_r.tx_div_cnt + 16'd1;

      // A pin change counts once the second and third stages agree
      s_nxt.rx_sync = {s_r.rx_sync[1:0], rx_serial};
      if (s_r.rx_sync[1] == s_r.rx_sync[2])
      begin
         s_nxt.rx_lvl = s_r.rx_sync[2];
      end

      //////////////////////////////////////////////////////////////////////
      // Bus: read data and the read side effect are taken at the address
      // phase so the answer is ready with zero wait states
      if (addr_ph && !hwrite)
      begin
         s_nxt.rdata = read_mux(s_r, haddr);
      end
      if (rd_rxbuf)
      begin
         s_nxt.da = 1'b0;
      end
      s_nxt.dp_wr = addr_ph && hwrite;
      if (addr_ph)
      begin
         s_nxt.dp_addr = haddr;
      end
      if (s_r.dp_wr)
      begin
         unique case (s_r.dp_addr)
            asrt_pkg::OFS_CTRL: s_nxt.cfg = hwdata[asrt_pkg::CTRL_W-1:0];
            asrt_pkg::OFS_TX_DIV: s_nxt.tx_div = hwdata[15:0];
            asrt_pkg::OFS_RX_DIV: s_nxt.rx_div = hwdata[15:0];
            asrt_pkg::OFS_TXBUF:
            begin
               s_nxt.tx_buf = hwdata[7:0];
               s_nxt.tx_full = 1'b1;
            end
            default: s_nxt.tx_full = s_r.tx_full;
         endcase
      end

      //////////////////////////////////////////////////////////////////////
      // Receiver
      rx_smp = 1'b0;
      if (rx_tick)
      begin
         s_nxt.rx_prev = s_r.rx_lvl;
         s_nxt.rx_tick = s_r.rx_tick + 4'd1;
         unique case (s_r.rx_st)
            asrt_pkg::RX_IDLE:
            begin
               s_nxt.rx_tick = 4'h0;
               // Mark-to-space edge; the start tick itself counts as tick zero
               if (s_r.rx_prev && !s_r.rx_lvl)
               begin
                  s_nxt.rx_st = asrt_pkg::RX_START;
                  s_nxt.rx_tick = 4'h1;
               end
            end
            asrt_pkg::RX_START:
            begin
               // A start shorter than half a bit is back at mark here
               if (s_r.rx_tick == asrt_pkg::TICK_MID)
               begin
                  s_nxt.rx_tick = 4'h0;
                  s_nxt.rx_bit = 3'd0;
                  s_nxt.rx_st = s_r.rx_lvl ? asrt_pkg::RX_IDLE : asrt_pkg::RX_DATA;
               end
            end
            default:
            begin
               rx_smp = s_r.rx_tick == asrt_pkg::TICK_LAST && s_r.rx_st != asrt_pkg::RX_BRK;
            end
         endcase
         if (s_r.rx_st == asrt_pkg::RX_BRK)
         begin
            s_nxt.rx_tick = 4'h0;
            if (s_r.rx_lvl)
            begin
               s_nxt.rx_st = asrt_pkg::RX_IDLE;
            end
         end
      end
      if (rx_smp)
      begin
         unique case (s_r.rx_st)
            asrt_pkg::RX_DATA:
            begin
               s_nxt.rx_sh = {s_r.rx_lvl, s_r.rx_sh[7:1]};
               s_nxt.rx_bit = s_r.rx_bit + 3'd1;
               if (s_r.rx_bit == last_bit)
               begin
                  s_nxt.rx_st = s_r.cfg.par_en ? asrt_pkg::RX_PAR : asrt_pkg::RX_STOP;
               end
            end
            asrt_pkg::RX_PAR:
            begin
               s_nxt.rx_par = s_r.rx_lvl;
               s_nxt.rx_st = asrt_pkg::RX_STOP;
            end
            default:
            begin
               // Stop sample: transfer, then flags clocked by data-available
               s_nxt.rx_hold = align(s_r.rx_sh, s_r.cfg.len);
               s_nxt.da = 1'b1;
               s_nxt.oerr = s_r.da;
               s_nxt.ferr = !s_r.rx_lvl;
               s_nxt.perr = s_r.cfg.par_en &&
                  (par_of(align(s_r.rx_sh, s_r.cfg.len), s_r.cfg.len) ^ s_r.rx_par ^ s_r.cfg.par_odd);
               s_nxt.rx_st = s_r.rx_lvl ? asrt_pkg::RX_IDLE : asrt_pkg::RX_BRK;
            end
         endcase
      end
      if (!s_r.cfg.par_en)
      begin
         s_nxt.perr = 1'b0;
      end

      //////////////////////////////////////////////////////////////////////
      // Transmitter: a character only enters the shift register while
      // end-of-character is high, or at the very tick the last stop ends
      if (tx_tick)
      begin
         s_nxt.tx_tick = s_r.tx_tick + 6'd1;
         unique case (s_r.tx_st)
            asrt_pkg::TX_IDLE:
            begin
               s_nxt.tx_line = 1'b1;
               s_nxt.tx_tick = 6'h00;
            end
            asrt_pkg::TX_START:
            begin
               if (s_r.tx_tick[3:0] == asrt_pkg::TICK_LAST)
               begin
                  s_nxt.tx_tick = 6'h00;
                  s_nxt.tx_bit = 3'd1;
                  s_nxt.tx_st = asrt_pkg::TX_DATA;
                  s_nxt.tx_line = s_r.tx_sh[0];
               end
            end
            asrt_pkg::TX_DATA:
            begin
               if (s_r.tx_tick[3:0] == asrt_pkg::TICK_LAST)
               begin
                  s_nxt.tx_tick = 6'h00;
                  s_nxt.tx_bit = s_r.tx_bit + 3'd1;
                  s_nxt.tx_line = s_r.tx_sh[s_r.tx_bit];
                  if (s_r.tx_bit == last_bit + 3'd1 || (s_r.tx_bit == 3'd0 && last_bit == 3'd7))
                  begin
                     s_nxt.tx_st = s_r.cfg.par_en ? asrt_pkg::TX_PAR : asrt_pkg::TX_STOP;
                     s_nxt.tx_line = s_r.cfg.par_en ?
                        par_of(s_r.tx_sh, s_r.cfg.len) ^ s_r.cfg.par_odd : 1'b1;
                  end
               end
            end
            asrt_pkg::TX_PAR:
            begin
               if (s_r.tx_tick[3:0] == asrt_pkg::TICK_LAST)
               begin
                  s_nxt.tx_tick = 6'h00;
                  s_nxt.tx_st = asrt_pkg::TX_STOP;
                  s_nxt.tx_line = 1'b1;
               end
            end
            default:
            begin
               // Stop length set by how many ticks the stop state is held
               if (s_r.tx_tick == stop_last)
               begin
                  s_nxt.tx_tick = 6'h00;
                  s_nxt.tx_st = asrt_pkg::TX_IDLE;
               end
            end
         endcase
         // Load on a tick so the start bit is a full sixteen ticks
         if ((eoc || (s_r.tx_st == asrt_pkg::TX_STOP && s_r.tx_tick == stop_last)) && s_r.tx_full)
         begin
            s_nxt.tx_sh = s_r.tx_buf;
            s_nxt.tx_full = 1'b0;
            s_nxt.tx_st = asrt_pkg::TX_START;
            s_nxt.tx_tick = 6'h00;
            s_nxt.tx_line = 1'b0;
         end
      end
      // A buffer write in the same cycle wins over the load's clear
      if (s_r.dp_wr && s_r.dp_addr == asrt_pkg::OFS_TXBUF)
      begin
         s_nxt.tx_full = 1'b1;
      end
      // A new character wins over a simultaneous host read
      if (rx_smp && s_r.rx_st == asrt_pkg::RX_STOP)
      begin
         s_nxt.da = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         s_r <= '0;
         s_r.rx_sync <= 3'b111;
         s_r.rx_lvl <= 1'b1;
         s_r.rx_prev <= 1'b1;
         s_r.rx_st <= asrt_pkg::RX_IDLE;
         s_r.tx_st <= asrt_pkg::TX_IDLE;
         s_r.tx_line <= 1'b1;
         s_r.cfg <= asrt_pkg::CTRL_RST;
         s_r.tx_div <= asrt_pkg::DIV_RST;
         s_r.rx_div <= asrt_pkg::DIV_RST;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

endmodule

// *** sim/asrt_core_checker.sv ***
`timescale 1ns/1ns
module asrt_core_checker #(
   parameter int DIV_W = 16
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Bus
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   // Serial
   input wire logic rx_serial,
   input wire logic tx_serial
);
   logic wr_ctrl_r;
   logic par_on_r;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   //////////////////////////////////////////
   // Mirror of the parity enable, since the checker only sees the bus and serial pins
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         wr_ctrl_r <= 1'b0;
         par_on_r <= 1'b0;
      end
      else
      begin
         wr_ctrl_r <= hsel && htrans[1] && hready && hwrite && haddr == asrt_pkg::OFS_CTRL;
         if (wr_ctrl_r)
            par_on_r <= hwdata[asrt_pkg::CTRL_PAR_EN];
      end
   end
   sequence s_read(logic [7:0] a);
      hsel && htrans[1] && hready && !hwrite && haddr == a;
   endsequence
   //////////////////////////////////////////
   a_reset_mark_idle: assert property ($fell(rst) |-> tx_serial && hrdata == 32'h0)
      else $error("serial output or read data wrong after reset");
   a_bus_ready_okay: assert property (hreadyout && !hresp)
      else $error("slave stalled or answered with error");
   a_unmapped_reads_zero: assert property (hsel && htrans[1] && hready && !hwrite && haddr > 8'h17 |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_txbuf_reads_zero: assert property (s_read(asrt_pkg::OFS_TXBUF) |=> hrdata == 32'h0)
      else $error("write-only buffer read not zero");
   a_status_upper_zero: assert property (s_read(asrt_pkg::OFS_STATUS) |=> hrdata[31:5] == 27'h0)
      else $error("status shows bits beyond the flags");
   a_parity_off_quiet: assert property (s_read(asrt_pkg::OFS_STATUS) ##1 !par_on_r |-> !hrdata[asrt_pkg::STAT_PERR])
      else $error("parity error shown with parity disabled");
   a_read_clears_da: assert property (s_read(asrt_pkg::OFS_RXBUF) ##[1:4] s_read(asrt_pkg::OFS_STATUS)
      |=> !hrdata[asrt_pkg::STAT_DA])
      else $error("data available still set after buffer read");
   a_start_full_bit: assert property ($fell(tx_serial) |-> !tx_serial [*8] ##1 !tx_serial [*8])
      else $error("transmit start bit shorter than sixteen ticks");
   a_mark_min_bit: assert property ($rose(tx_serial) |-> tx_serial [*8] ##1 tx_serial [*8])
      else $error("mark run on transmit line shorter than one bit");
endmodule

bind asrt_core asrt_core_checker #(.DIV_W(DIV_W)) u_chk (.core_clk(core_clk), .rst(rst), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx_serial(rx_serial), .tx_serial(tx_serial));

// *** sim/asrt_term.sv ***
`timescale 1ns/1ns
module asrt_term #(
   parameter int BIT = 16
) (
   // Clock
   input wire logic core_clk,
   // Serial line
   input wire logic tx_serial,
   output logic rx_serial
);
   int nbits = 8;
   int par_en = 0;
   int hi_cnt = 0;
   logic [8:0] data_q [$];
   int gap_q [$];
   //////////////////////////////////////////
   task automatic put_bit(logic b, int n);
      rx_serial <= b;
      repeat (n) @(posedge core_clk);
   endtask
   // Kind: 0 good, 1 bad parity, 2 bad stop, 3 two characters, 4 short start, 5 stuck space
   task automatic send(logic [7:0] d, int nb, logic pe, logic po, int kind);
      logic p;
      p = ^d ^ po ^ (kind == 1);
      if (kind == 4)
         put_bit(1'b0, BIT / 4);
      else if (kind == 5)
         put_bit(1'b0, 12 * BIT);
      else
         repeat (kind == 3 ? 2 : 1)
         begin
            put_bit(1'b0, BIT);
            for (int i = 0; i < nb; i++)
               put_bit(d[i], BIT);
            if (pe)
               put_bit(p, BIT);
            put_bit(kind != 2, BIT);
         end
      // Line returns to mark so a bad stop cannot look like a new start
      put_bit(1'b1, 2 * BIT);
   endtask
   //////////////////////////////////////////
   // Frames are sampled mid-bit; gap counts mark cycles before each start
   initial
   begin
      logic [8:0] fr;
      int gap;
      rx_serial = 1'b1;
      forever
      begin
         @(posedge core_clk);
         if (tx_serial === 1'b0)
         begin
            gap = hi_cnt;
            fr = 9'h0;
            repeat (BIT / 2 - 1) @(posedge core_clk);
            for (int i = 0; i < nbits + par_en; i++)
            begin
               repeat (BIT) @(posedge core_clk);
               fr[i] = tx_serial;
            end
            repeat (BIT / 2) @(posedge core_clk);
            data_q.push_back(fr);
            gap_q.push_back(gap);
            hi_cnt = 0;
         end
         else
            hi_cnt++;
      end
   end
endmodule

// *** sim/asrt_core_test.sv ***
`timescale 1ns/1ns
module asrt_core_test;
   logic core_clk;
   logic rst;
   logic hsel;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic rx_serial;
   logic tx_serial;
   int error_cnt = 0;
   int check_count = 0;
   logic [31:0] rd;
   logic p;
   int stop_t [4] = '{16, 24, 32, 32};
   // Receive cases in kind order: good, bad parity, bad stop, overrun, short start, stuck space
   logic [7:0] rx_ctrl [6] = '{8'h30, 8'h21, 8'h30, 8'h30, 8'h30, 8'h30};
   logic [7:0] rx_dat [6] = '{8'hC3, 8'h55, 8'h0F, 8'h81, 8'h00, 8'h00};
   logic [7:0] rx_st [6] = '{8'h11, 8'h13, 8'h15, 8'h19, 8'h18, 8'h15};
   logic [7:0] rx_buf [6] = '{8'hC3, 8'h55, 8'h0F, 8'h81, 8'h81, 8'h00};

   asrt_core dut (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .rx_serial(rx_serial), .tx_serial(tx_serial));
   asrt_term term (.core_clk(core_clk), .tx_serial(tx_serial), .rx_serial(rx_serial));
   //////////////////////////////////////////
   task automatic check(string name, logic [31:0] exp, logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask
   task automatic bus(logic [7:0] a, logic wr, logic [31:0] wd);
      @(posedge core_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rchk(string name, logic [7:0] a, logic [31:0] exp);
      bus(a, 1'b0, 32'h0);
      check(name, exp, rd);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   //////////////////////////////////////////
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // The whole run needs well under ten thousand cycles
   initial
   begin
      repeat (50000) @(posedge core_clk);
      error_cnt++;
      test_done();
   end
   initial
   begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      rchk("ctrl", asrt_pkg::OFS_CTRL, 32'(asrt_pkg::CTRL_RST));
      rchk("tx_div", asrt_pkg::OFS_TX_DIV, 32'(asrt_pkg::DIV_RST));
      rchk("status", asrt_pkg::OFS_STATUS, 32'h10);
      rchk("txbuf", asrt_pkg::OFS_TXBUF, 32'h0);
      rchk("unmapped", 8'h18, 32'h0);
      check("tx idle", 32'h1, {31'h0, tx_serial});
      bus(asrt_pkg::OFS_TX_DIV, 1'b1, 32'h1);
      bus(asrt_pkg::OFS_RX_DIV, 1'b1, 32'h1);
      $display("test reset done");
      // Each length, stop code and parity sense; gap counting starts after the last frame bit so the gap is the stop alone
      for (int i = 0; i < 4; i++)
      begin
         p = 1'b1 ^ i[0];
         term.nbits = 5 + i;
         term.par_en = (i != 0);
         bus(asrt_pkg::OFS_CTRL, 1'b1, 32'(i * 16 + i * 4 + i[0] * 2 + (i != 0)));
         term.data_q.delete();
         term.gap_q.delete();
         bus(asrt_pkg::OFS_TXBUF, 1'b1, 32'h1);
         repeat (3) @(posedge core_clk);
         check("tx start", 32'h0, {31'h0, tx_serial});
         bus(asrt_pkg::OFS_TXBUF, 1'b1, 32'h1);
         rchk("tx busy", asrt_pkg::OFS_STATUS, 32'h0);
         for (int w = 0; w < 2000 && term.gap_q.size() < 2; w++)
            @(posedge core_clk);
         check("frame", 32'h1 | (i != 0 ? 32'(p) << (5 + i) : 32'h0), 32'(term.data_q[1]));
         check("gap", 32'(stop_t[i]), 32'(term.gap_q[1]));
         repeat (40) @(posedge core_clk);
      end
      check("tx idle", 32'h1, {31'h0, tx_serial});
      $display("test transmit done");
      for (int i = 0; i < 6; i++)
      begin
         bus(asrt_pkg::OFS_CTRL, 1'b1, 32'(rx_ctrl[i]));
         term.send(rx_dat[i], 5 + rx_ctrl[i][5:4], rx_ctrl[i][0], rx_ctrl[i][1], i);
         rchk("rx status", asrt_pkg::OFS_STATUS, 32'(rx_st[i]));
         rchk("rx data", asrt_pkg::OFS_RXBUF, 32'(rx_buf[i]));
         rchk("rx cleared", asrt_pkg::OFS_STATUS, 32'(rx_st[i] & 8'hFE));
      end
      $display("test receive done");
      test_done();
   end
endmodule
